// ===== adcsq_pkg.sv
// Package of constants and types for the converter sequencer
package adcsq_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_DATA0 = 8'h20;
  localparam logic [7:0] OFS_DATA_LAST = 8'h5C;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int POS_FLAG = 7;
  localparam int POS_IE = 6;
  localparam int POS_START = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hFC;
  localparam logic [7:0] STAT_WMASK = 8'h6F;

  // ----------------------------------------
  // Cycle counts per clock select code
  // ----------------------------------------
  localparam logic [9:0] FIRST_00 = 10'h212;
  localparam logic [9:0] FIRST_01 = 10'h10A;
  localparam logic [9:0] FIRST_10 = 10'h086;
  localparam logic [9:0] FIRST_11 = 10'h044;
  localparam logic [9:0] NEXT_00 = 10'h200;
  localparam logic [9:0] NEXT_01 = 10'h100;
  localparam logic [9:0] NEXT_10 = 10'h080;
  localparam logic [9:0] NEXT_11 = 10'h040;
  localparam logic [9:0] DLY_00 = 10'h012;
  localparam logic [9:0] DLY_01 = 10'h00A;
  localparam logic [9:0] DLY_10 = 10'h006;
  localparam logic [9:0] DLY_11 = 10'h004;
  localparam logic [3:0] SAR_BITS = 4'hA;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] trig_sel;
    logic scan_enable_bit;
    logic scan_size_bit;
    logic [1:0] clk_sel;
    logic [1:0] rsvd;
  } adcsq_ctrl_t;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_DELAY = 2'b01,
    ST_CONV = 2'b10
  } adcsq_state_t;

endpackage

// ===== adcsq_top.sv
// Converter sequencer with AHB-Lite register slave
`timescale 1ns/1ps
// Contract
// [RULE1] Two-bit trigger select enables hardware starts; 01 selects timer unit a.
// [RULE2] Mode field: upper bit 0 single, 10 four-channel scan, 11 eight-channel scan.
// [RULE3] Clock select codes give 530, 266, 134, 68 state conversion times.
// [RULE4] Software writes clock select only while start bit is 0.
// [RULE5] Control bits 1 and 0 read 0, ignore writes; others reset to 0.
// [RULE6] Successive approximation gives a 10-bit result per channel.
// [RULE7] Software clears start bit before changing mode or channel.
// [RULE8] One write may set start together with new mode or channel; code starts from the channel held before that write.
// [RULE9] Single mode converts once and stores into that channel's register.
// [RULE10] Single completion sets end flag; irq when enable is 1.
// [RULE11] Single: start bit self-clears at end; clearing it stops to wait.
// [RULE12] Four-scan group start from upper channel bits; eight-scan starts at 0.
// [RULE13] Scan stores each channel result on its completion, in order.
// [RULE14] Group done sets flag, irq if enabled, restarts at first channel.
// [RULE15] Scan repeats while start is 1; clear stops; set restarts group.
// [RULE16] Start delay precedes sampling; 18 to 33 slowest, 4 to 5 fastest.
// [RULE17] Start delay varies with write timing against conversion clock phase.
// [RULE18] First scan conversion takes the single-mode time including delay.
// [RULE19] Later scan conversions take 512, 256, 128 or 64 states.
// [RULE20] Trigger select 11: falling edge on trigger pin sets start bit.
// [RULE21] Pin-started conversion behaves exactly like a software start.
// [RULE22] Reset or standby entry clears the start bit in scan mode.
// [RULE23] End flag clears only by writing 0; writing 1 has no effect.
// [RULE24] Interrupt request high only while enable and end flag are 1.
// [RULE25] Triggers sampled on system clock; ignored while start bit is 1.
module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int NCH = 16
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [7:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Triggers and power states
  input wire logic TIMER_UNIT_A_TRIG,
  input wire logic TIMER_UNIT_B_TRIG,
  input wire logic EXT_TRIGGER_PIN,
  input wire logic STANDBY,
  // Analog front end
  output logic [3:0] ANALOG_CHANNEL,
  output logic SAMPLE_HOLD,
  output logic [9:0] DAC_CODE,
  input wire logic COMP_HIGH,
  // Interrupt request
  output logic CONVERSION_END_IRQ
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  adcsq_ctrl_t ctrl_ff;
  logic [7:0] stat_ff;
  logic [9:0] data_ff [NCH];
  adcsq_state_t state_ff;
  logic [9:0] cnt_ff;
  logic [9:0] sar_ff;
  logic [3:0] bit_ff;
  logic [3:0] chan_ff;
  logic first_ff;
  logic [4:0] phase_ff;
  logic pin_ff;
  logic wr_pend_ff;
  logic [7:0] addr_ff;
  logic [31:0] rdata_ff;
  logic irq_ff;
  logic sh_ff;
  logic [9:0] dac_ff;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire addr_phase = HSEL & HREADY & HTRANS[1];
  wire wr_ctrl = wr_pend_ff & (addr_ff == OFS_CONTROL);
  wire wr_stat = wr_pend_ff & (addr_ff == OFS_STATUS);
  wire [7:0] wbyte = HWDATA[7:0];
  wire start_now = stat_ff[POS_START];
  wire scan_mode = ctrl_ff.scan_enable_bit;
  wire [3:0] ch_sel = stat_ff[3:0];
  wire [1:0] cks = ctrl_ff.clk_sel;
  wire [7:0] nxt_ctrl = wr_ctrl ? (wbyte & CTRL_WMASK) : ctrl_ff;

  // Data register index from a byte address
  function automatic logic [3:0] data_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - OFS_DATA0;
    return d[5:2];
  endfunction

  wire rd_is_data = (HADDR >= OFS_DATA0) & (HADDR <= OFS_DATA_LAST);

  // ----------------------------------------
  // Trigger sampling
  // ----------------------------------------
  wire pin_fall = pin_ff & ~EXT_TRIGGER_PIN;
  wire hw_trig = (ctrl_ff.trig_sel == 2'b01) ? TIMER_UNIT_A_TRIG : //RULE1
                 (ctrl_ff.trig_sel == 2'b10) ? TIMER_UNIT_B_TRIG :
                 (ctrl_ff.trig_sel == 2'b11) ? pin_fall : 1'b0; //RULE20
  wire trig_start = hw_trig & ~start_now; //RULE25

  // ----------------------------------------
  // Group and timing selection
  // ----------------------------------------
  wire [3:0] grp_first = ~scan_mode ? ch_sel :
                         ctrl_ff.scan_size_bit ? 4'h0 : {ch_sel[3:2], 2'b00}; //RULE12
  wire [3:0] grp_last = ~scan_mode ? ch_sel :
                        ctrl_ff.scan_size_bit ? {1'b0, ch_sel[2:0]} : ch_sel; //RULE2
  wire [9:0] first_time = (cks == 2'b00) ? FIRST_00 : (cks == 2'b01) ? FIRST_01 :
                          (cks == 2'b10) ? FIRST_10 : FIRST_11; //RULE3
  wire [9:0] next_time = (cks == 2'b00) ? NEXT_00 : (cks == 2'b01) ? NEXT_01 :
                         (cks == 2'b10) ? NEXT_10 : NEXT_11; //RULE19
  wire [9:0] dly_base = (cks == 2'b00) ? DLY_00 : (cks == 2'b01) ? DLY_01 :
                        (cks == 2'b10) ? DLY_10 : DLY_11;
  wire [4:0] phase_mask = (cks == 2'b00) ? 5'h0F : (cks == 2'b01) ? 5'h07 :
                          (cks == 2'b10) ? 5'h03 : 5'h01;
  wire [9:0] dly_time = dly_base + {5'h00, phase_ff & phase_mask}; //RULE17
  wire [9:0] slot = scan_mode & ~first_ff ? next_time : first_time; //RULE18
  wire [9:0] conv_time = slot - dly_base - {5'h00, phase_mask}; //RULE16
  wire [9:0] per_bit = conv_time >> 4;

  // ----------------------------------------
  // Start bit and sequencer events
  // ----------------------------------------
  wire sw_start = wr_stat & wbyte[POS_START] & ~start_now; //RULE8
  wire sw_stop = wr_stat & ~wbyte[POS_START];
  wire begin_conv = sw_start | trig_start; //RULE21
  wire conv_done = (state_ff == ST_CONV) & (cnt_ff == 10'h001) & start_now & ~sw_stop;
  wire grp_done = conv_done & (chan_ff == grp_last);
  wire end_evt = grp_done; //RULE10 RULE14
  wire stop_now = sw_stop | STANDBY; //RULE11 RULE22
  wire [9:0] trial = sar_ff | (10'h200 >> bit_ff);
  wire bit_tick = (state_ff == ST_CONV) & ~sh_ff & (cnt_ff > 10'h001) &
                  (cnt_ff[1:0] == 2'b01) & (bit_ff < SAR_BITS);

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_ff <= CTRL_RESET; //RULE5
    end else if (wr_ctrl) begin
      ctrl_ff <= nxt_ctrl; //RULE5
    end
  end

  // ----------------------------------------
  // Status register
  // ----------------------------------------
  logic [7:0] nxt_stat;
  always_comb begin
    nxt_stat = stat_ff;
    if (wr_stat) begin
      nxt_stat = (stat_ff & ~STAT_WMASK) | (wbyte & STAT_WMASK);
      if (!wbyte[POS_FLAG]) begin
        nxt_stat[POS_FLAG] = 1'b0; //RULE23
      end
    end
    if (trig_start) begin
      nxt_stat[POS_START] = 1'b1; //RULE20
    end
    if (STANDBY) begin
      nxt_stat[POS_START] = 1'b0; //RULE22
    end
    if (grp_done & ~scan_mode) begin
      nxt_stat[POS_START] = 1'b0; //RULE11
    end
    if (end_evt) begin
      nxt_stat[POS_FLAG] = 1'b1; //RULE10
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      stat_ff <= STAT_RESET;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= ST_WAIT;
      cnt_ff <= 10'h000;
      chan_ff <= 4'h0;
      first_ff <= 1'b1;
      sar_ff <= 10'h000;
      bit_ff <= 4'h0;
      sh_ff <= 1'b0;
    end else if (stop_now) begin
      state_ff <= ST_WAIT; //RULE11
      sh_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_WAIT: begin
          if (begin_conv) begin
            state_ff <= ST_DELAY; //RULE16
            chan_ff <= grp_first; //RULE15
            first_ff <= 1'b1;
            cnt_ff <= dly_time;
          end
        end
        ST_DELAY: begin
          if (cnt_ff <= 10'h001) begin
            state_ff <= ST_CONV;
            cnt_ff <= conv_time;
            sar_ff <= 10'h000;
            bit_ff <= 4'h0;
            sh_ff <= 1'b1;
          end else begin
            cnt_ff <= cnt_ff - 10'h001;
          end
        end
        ST_CONV: begin
          cnt_ff <= cnt_ff - 10'h001;
          if (cnt_ff == conv_time - per_bit) begin
            sh_ff <= 1'b0;
          end
          if (bit_tick) begin
            sar_ff <= COMP_HIGH ? trial : sar_ff; //RULE6
            bit_ff <= bit_ff + 4'h1;
          end
          if (conv_done) begin
            sh_ff <= 1'b1;
            sar_ff <= 10'h000;
            bit_ff <= 4'h0;
            first_ff <= 1'b0;
            if (grp_done & ~scan_mode) begin
              state_ff <= ST_WAIT; //RULE9
              sh_ff <= 1'b0;
            end else begin
              chan_ff <= grp_done ? grp_first : chan_ff + 4'h1; //RULE14
              cnt_ff <= next_time; //RULE19
            end
          end
        end
        default: begin
          state_ff <= ST_WAIT;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Result registers
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_data
      always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          data_ff[gi] <= 10'h000;
        end else if (conv_done & (chan_ff == 4'(gi))) begin
          data_ff[gi] <= sar_ff; //RULE9 RULE13
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Bus slave and outputs
  // ----------------------------------------
  wire [31:0] rd_mux = (HADDR == OFS_STATUS) ? {24'h000000, nxt_stat} :
                       (HADDR == OFS_CONTROL) ? {24'h000000, nxt_ctrl} :
                       rd_is_data ? {22'h000000, data_ff[data_index(HADDR)]} : 32'h00000000;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
      rdata_ff <= 32'h00000000;
      pin_ff <= 1'b1;
      phase_ff <= 5'h00;
      irq_ff <= 1'b0;
      dac_ff <= 10'h000;
    end else begin
      wr_pend_ff <= addr_phase & HWRITE;
      addr_ff <= addr_phase ? HADDR : addr_ff;
      rdata_ff <= addr_phase ? rd_mux : rdata_ff;
      pin_ff <= EXT_TRIGGER_PIN;
      phase_ff <= phase_ff + 5'h01;
      irq_ff <= nxt_stat[POS_IE] & nxt_stat[POS_FLAG]; //RULE24
      dac_ff <= trial;
    end
  end

  assign HRDATA = rdata_ff;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign ANALOG_CHANNEL = chan_ff;
  assign SAMPLE_HOLD = sh_ff;
  assign DAC_CODE = dac_ff;
  assign CONVERSION_END_IRQ = irq_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  irq_follow_a: assert property (@(posedge CLK) disable iff (!ARST_N) //RULE24
    CONVERSION_END_IRQ == $past(stat_ff[POS_IE] & stat_ff[POS_FLAG]) || $past(end_evt | wr_stat))
    else $error("irq does not follow flag and enable");
  rsvd_zero_a: assert property (@(posedge CLK) disable iff (!ARST_N) //RULE5
    ctrl_ff[1:0] == 2'b00) else $error("reserved control bits set");
  flag_set_a: assert property (@(posedge CLK) disable iff (!ARST_N) //RULE10
    end_evt |=> stat_ff[POS_FLAG]) else $error("end flag not set");
  flag_one_a: assert property (@(posedge CLK) disable iff (!ARST_N) //RULE23
    wr_stat & wbyte[POS_FLAG] & ~stat_ff[POS_FLAG] & ~end_evt |=> ~stat_ff[POS_FLAG])
    else $error("writing one set end flag");
  single_clr_a: assert property (@(posedge CLK) disable iff (!ARST_N) //RULE11
    grp_done & ~scan_mode & ~trig_start |=> ~stat_ff[POS_START])
    else $error("start bit not cleared in single mode");
  scan_keep_a: assert property (@(posedge CLK) disable iff (!ARST_N) //RULE15
    grp_done & scan_mode & ~STANDBY |=> stat_ff[POS_START] && state_ff == ST_CONV)
    else $error("scan did not continue");
  ext_trig_a: assert property (@(posedge CLK) disable iff (!ARST_N) //RULE20
    ctrl_ff.trig_sel == 2'b11 && pin_fall && !start_now && !STANDBY |=> stat_ff[POS_START])
    else $error("pin edge did not start");
  scan_next_a: assert property (@(posedge CLK) disable iff (!ARST_N) //RULE19
    conv_done & scan_mode & ~stop_now |=> cnt_ff == $past(next_time))
    else $error("scan slot length wrong");
  stop_wait_a: assert property (@(posedge CLK) disable iff (!ARST_N) //RULE22
    STANDBY |=> state_ff == ST_WAIT && !stat_ff[POS_START])
    else $error("standby did not stop");
  sar_bits_a: assert property (@(posedge CLK) disable iff (!ARST_N) //RULE6
    conv_done |-> bit_ff == SAR_BITS) else $error("result has unresolved bits");
  start_dly_a: assert property (@(posedge CLK) disable iff (!ARST_N) //RULE16
    state_ff == ST_WAIT && begin_conv && !stop_now && !wr_ctrl |=>
      state_ff == ST_DELAY && cnt_ff >= dly_base && cnt_ff <= dly_base + {5'h00, phase_mask})
    else $error("start delay out of range");

endmodule

// ===== adcsq_afe_model.sv
// Behavioural analog front end for the converter sequencer
`timescale 1ns/1ps
module adcsq_afe_model (
  // Clock
  input wire logic clk,
  // Front end
  input wire logic [3:0] analog_channel,
  input wire logic sample_hold,
  input wire logic [9:0] dac_code,
  output logic comp_high
);
  logic [9:0] held_ff;
  // Per-channel level held while sampling
  always_ff @(posedge clk) begin
    if (sample_hold) begin
      held_ff <= {analog_channel, 6'h2A};
    end
  end
  // Keep trial bit while input is at or above it
  assign comp_high = (dac_code <= held_ff);
endmodule

// ===== tb.sv
// Register-level testbench for the converter sequencer
`timescale 1ns/1ps
module tb;
  import adcsq_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic trig_a = 1'b0;
  logic trig_b = 1'b0;
  logic ext_pin = 1'b1;
  logic standby = 1'b0;
  logic [3:0] chan;
  logic sh;
  logic [9:0] dac;
  logic comp;
  logic irq;
  int miscompares = 0;
  int checks = 0;
  int n;
  logic [31:0] rd;
  int tmax[4] = '{530, 266, 134, 68};
  int tmin[4] = '{515, 259, 131, 67};
  logic [2:0] fm[4] = '{3'h7, 3'h1, 3'h2, 3'h4};

  always #4 clk = ~clk;

  adcsq_top dut (.CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .TIMER_UNIT_A_TRIG(trig_a), .TIMER_UNIT_B_TRIG(trig_b),
    .EXT_TRIGGER_PIN(ext_pin), .STANDBY(standby), .ANALOG_CHANNEL(chan), .SAMPLE_HOLD(sh),
    .DAC_CODE(dac), .COMP_HIGH(comp), .CONVERSION_END_IRQ(irq));

  adcsq_afe_model afe (.clk(clk), .analog_channel(chan), .sample_hold(sh), .dac_code(dac),
    .comp_high(comp));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %0t got %h exp %h", $time, s, e);
    end
  endtask

  task automatic rdy();
    int k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      complete_run();
    end
  endtask

  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rdy();
  endtask

  task automatic br(input logic [7:0] a, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    rdy();
    r = hrdata;
  endtask

  task automatic wirq(output int c, input int lim);
    c = 0;
    while (irq !== 1'b1 && c < lim) begin
      @(posedge clk);
      c++;
    end
    if (irq !== 1'b1) begin
      miscompares++;
      complete_run();
    end
  endtask

  task automatic go(input logic [7:0] c, input logic [7:0] s);
    bw(OFS_STATUS, {24'h0, 8'h40 | (s & 8'h0F)});
    bw(OFS_CONTROL, {24'h0, c});
    bw(OFS_STATUS, {24'h0, s});
  endtask

  task automatic fire(input logic [2:0] m);
    trig_a <= m[0];
    trig_b <= m[1];
    ext_pin <= ~m[2];
    @(posedge clk);
    trig_a <= 1'b0;
    trig_b <= 1'b0;
    @(posedge clk);
    ext_pin <= 1'b1;
  endtask

  function automatic logic [31:0] expv(input int ch);
    return {22'h0, 4'(ch), 6'h2A};
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    br(OFS_CONTROL, rd);
    chk(rd, {24'h0, CTRL_RESET});
    br(OFS_STATUS, rd);
    chk(rd, {24'h0, STAT_RESET});
    bw(OFS_CONTROL, 32'hFF);
    br(OFS_CONTROL, rd);
    chk(rd, 32'hFC);
    br(8'h10, rd);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      go({4'h0, 2'(i), 2'h0}, 8'h64 + 8'(i));
      wirq(n, 700);
      chk(32'(n >= tmin[i] && n <= tmax[i] + 3), 32'h1);
      br(OFS_STATUS, rd);
      chk(rd, 32'hE4 + 32'(i) - 32'h20);
      br(OFS_DATA0 + 8'(4 * (4 + i)), rd);
      chk(rd, expv(4 + i));
    end
    bw(OFS_STATUS, 32'hC7);
    br(OFS_STATUS, rd);
    chk(rd, 32'hC7);
    chk({31'h0, irq}, 32'h1);
    bw(OFS_STATUS, 32'h87);
    br(OFS_STATUS, rd);
    chk({31'h0, irq}, 32'h0);
    bw(OFS_STATUS, 32'h07);
    br(OFS_STATUS, rd);
    chk(rd, 32'h07);
    $display("test single done");
    go(8'h2C, 8'h6F);
    wirq(n, 400);
    chk(32'(n >= 259 && n <= 263), 32'h1);
    bw(OFS_STATUS, 32'h6F);
    repeat (2) @(posedge clk);
    wirq(n, 400);
    chk(32'(n >= 248 && n <= 256), 32'h1);
    br(OFS_STATUS, rd);
    chk(rd, 32'hEF);
    for (int j = 12; j < 16; j++) begin
      br(OFS_DATA0 + 8'(4 * j), rd);
      chk(rd, expv(j));
    end
    bw(OFS_STATUS, 32'h4F);
    repeat (602) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    go(8'h3C, 8'h63);
    wirq(n, 400);
    for (int j = 0; j < 4; j++) begin
      br(OFS_DATA0 + 8'(4 * j), rd);
      chk(rd, expv(j));
    end
    repeat (20) @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    br(OFS_STATUS, rd);
    chk({31'h0, rd[POS_START]}, 32'h0);
    go(8'h00, 8'h61);
    repeat (100) @(posedge clk);
    bw(OFS_STATUS, 32'h41);
    repeat (702) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("test scan done");
    for (int i = 0; i < 4; i++) begin
      go({2'(i), 6'h1C}, 8'h42);
      fire(fm[i]);
      repeat (2) @(posedge clk);
      br(OFS_STATUS, rd);
      chk({31'h0, rd[POS_START]}, 32'(i != 0));
      if (i != 0) begin
        wirq(n, 100);
        chk({31'h0, irq}, 32'h1);
        br(OFS_DATA0 + 8'h08, rd);
        chk(rd, expv(2));
      end
    end
    $display("test trigger done");
    complete_run();
  end
endmodule
